// >>> hw/dpc_params.svh
// Purpose: Named constants of the potentiometer command decoder
// Assumes: Included by both design files of the block
// Notes:   Definitions only
`ifndef DPC_PARAMS_SVH
`define DPC_PARAMS_SVH

// ----------------------------------------------------------------
// Command word layout
// ----------------------------------------------------------------
`define DPC_WORD_BITS     16
`define DPC_CTL_HI        15
`define DPC_CTL_LO        12
`define DPC_ADR_HI        11
`define DPC_ADR_LO        8
`define DPC_DAT_HI        7
`define DPC_CNT_BITS      6
`define DPC_CNT_MAX       6'h3f
`define DPC_CNT_ONE       6'h01
`define DPC_MIN_EDGES     6'h10
`define DPC_UNIT_MASK     6'h07

// ----------------------------------------------------------------
// Control codes and readback selectors
// ----------------------------------------------------------------
`define DPC_CMD_NOP       4'h0
`define DPC_CMD_WIPER     4'h1
`define DPC_CMD_PRELOAD   4'h2
`define DPC_CMD_READ      4'h3
`define DPC_CMD_NVCOPY    4'h7
`define DPC_CMD_SWRESET   4'hb
`define DPC_CMD_SHUTDOWN  4'hc
`define DPC_SEL_NV        2'h1
`define DPC_SEL_WIPER     2'h3

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define DPC_NV_INIT       8'h80
`define DPC_PIN_IDLE      5'h0f
`define DPC_STORE_TIME_US 18000
`define DPC_CLK_MHZ       250

`endif

// >>> hw/dpc_pkg.sv
// Purpose: Types of the potentiometer command decoder
// Assumes: Nothing
// Notes:   Constants live in dpc_params.svh
package dpc_pkg;
  typedef enum logic [1:0] {
    DPC_BOOT,
    DPC_IDLE,
    DPC_STORE
  } dpc_state_t;
endpackage : dpc_pkg

// >>> hw/dpc_link.sv
// Purpose: Serial-clock side: shifts the command word in, readback out
// Assumes: Host idles sclk low and stops it while sync_n is high
// Notes:   Word and edge count stay still between frames for capture
`timescale 1ns/100ps
`include "dpc_params.svh"

module dpc_link (
  // Resets and link clock
  input  wire logic                      rst,
  input  wire logic                      sclk,
  // Frame pins
  input  wire logic                      sync_n,
  input  wire logic                      sdi,
  // Readback word, held still by the core while a frame runs
  input  wire logic [`DPC_WORD_BITS-1:0] tx_word,
  // Received word and falling-edge count
  output logic      [`DPC_WORD_BITS-1:0] rx_word,
  output logic      [`DPC_CNT_BITS-1:0]  edge_count,
  // Open-drain data out
  output logic                           sdo_o,
  output logic                           sdo_oe_n
);
  import dpc_pkg::*;

  logic                      fresh;
  logic [`DPC_WORD_BITS-1:0] next_rx;
  logic [`DPC_CNT_BITS-1:0]  next_count;
  logic                      next_sdo;

  // ----------------------------------------------------------------
  // Frame start marker
  // ----------------------------------------------------------------
  // count restarts
  always_ff @(negedge sclk or posedge rst or posedge sync_n) begin
    if (rst || sync_n) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Shift in on falling edges
  // ----------------------------------------------------------------
  always_comb begin
    next_rx = fresh ? {tx_word[`DPC_WORD_BITS-2:0], sdi}
                    : {rx_word[`DPC_WORD_BITS-2:0], sdi};
    if (fresh) begin
      next_count = `DPC_CNT_ONE;
    end else if (edge_count == `DPC_CNT_MAX) begin
      next_count = `DPC_CNT_MAX;
    end else begin
      next_count = edge_count + `DPC_CNT_ONE;
    end
  end

  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      rx_word    <= '0;
      edge_count <= '0;
    end else begin
      rx_word    <= next_rx;
      edge_count <= next_count;
    end
  end

  // ----------------------------------------------------------------
  // Shift out on rising edges; released while the frame is idle
  // ----------------------------------------------------------------
  always_comb begin
    next_sdo = fresh ? tx_word[`DPC_WORD_BITS-1] : rx_word[`DPC_WORD_BITS-1];
  end

  always_ff @(posedge sclk or posedge rst or posedge sync_n) begin
    if (rst || sync_n) begin
      sdo_o    <= 1'b0;
      sdo_oe_n <= 1'b1;
    end else begin
      sdo_o    <= 1'b0;
      sdo_oe_n <= next_sdo;
    end
  end
endmodule : dpc_link

// >>> hw/dpc_core.sv
// Contract
// - Word is 16 bits: control, target, payload
// - Word arrives most significant bit first
// - Upper nibble alone selects the operation
// - 128-step variant ignores payload bit 0
// - Command 1 writes wiper setting directly
// - Command 2 writes preload, wiper untouched
// - Command 3 reads nonvolatile copy or wiper
// - Code 7 stores or restores by bit 0
// - Store takes 18 ms, commands ignored meanwhile
// - Power-up loads wiper from nonvolatile copy
// - Wiper setting is plain, rewritable, readable
// - Wiper code maps linearly to tap
// - Load pin copies preload into wiper
// - Write protect blocks all but restore; code still lets preload (command 2) and shutdown writes through
// - Reset pin refreshes wiper from nonvolatile copy
// - Frames not multiple of 8 edges dropped
//
// Purpose: Command decoder of a single-channel nonvolatile potentiometer
// Assumes: SPI framing only; nonvolatile cell modelled as a register
// Notes:   Pins are synchronised to clk; the serial side runs on sclk
`timescale 1ns/100ps
`include "dpc_params.svh"

module dpc_core #(
  parameter bit          HALF_STEPS   = 1'b0,
  parameter int unsigned STORE_CYCLES = `DPC_STORE_TIME_US * `DPC_CLK_MHZ,
  parameter logic [7:0]  NV_INIT      = `DPC_NV_INIT
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Serial link
  input  wire logic       sclk,
  input  wire logic       sync_n,
  input  wire logic       sdi,
  output logic            sdo_o,
  output logic            sdo_oe_n,
  // Control pins
  input  wire logic       load_wiper_n,
  input  wire logic       write_protect_n,
  input  wire logic       reset_n,
  input  wire logic       interface_select,
  // Status
  output logic [7:0]      wiper_setting_register,
  output logic [7:0]      preload,
  output logic [7:0]      nv_copy,
  output logic            shutdown,
  output logic            busy,
  output dpc_pkg::dpc_state_t state
);
  import dpc_pkg::*;

  localparam int TW = $clog2(STORE_CYCLES + 1);

  // Clears bit 0 on the 128-step variant
  function automatic logic [7:0] step_mask(input logic [7:0] v);
    step_mask = HALF_STEPS ? {v[7:1], 1'b0} : v;
  endfunction : step_mask

  // ----------------------------------------------------------------
  // Serial side
  // ----------------------------------------------------------------
  logic [`DPC_WORD_BITS-1:0] rx_word;
  logic [`DPC_CNT_BITS-1:0]  edge_count;
  logic [7:0]                readback;

  dpc_link u_link (
    .rst        (rst),
    .sclk       (sclk),
    .sync_n     (sync_n),
    .sdi        (sdi),
    .tx_word    ({8'h00, readback}),
    .rx_word    (rx_word),
    .edge_count (edge_count),
    .sdo_o      (sdo_o),
    .sdo_oe_n   (sdo_oe_n)
  );

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Order: interface_select, sync_n, load, protect, reset
  logic [4:0] pin_meta;
  logic [4:0] pin_s;
  logic       sync_prev;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_meta  <= `DPC_PIN_IDLE;
      pin_s     <= `DPC_PIN_IDLE;
      sync_prev <= 1'b1;
    end else begin
      pin_meta  <= {interface_select, sync_n, load_wiper_n, write_protect_n, reset_n};
      pin_s     <= pin_meta;
      sync_prev <= pin_s[3];
    end
  end

  logic spi_mode;
  logic sync_rise;
  logic load_on;
  logic protect_on;
  logic reset_on;

  assign spi_mode   = !pin_s[4];
  assign sync_rise  = pin_s[3] && !sync_prev;
  assign load_on    = !pin_s[2];
  assign protect_on = !pin_s[1];
  assign reset_on   = !pin_s[0];

  // ----------------------------------------------------------------
  // Frame capture
  // ----------------------------------------------------------------
  // Word and count were last moved before sync_n rose and sclk is idle
  // now, so sampling them two clk cycles later is safe.
  logic [`DPC_WORD_BITS-1:0] frame_word;
  logic [`DPC_CNT_BITS-1:0]  frame_cnt;
  logic                      frame_seen;
  logic [`DPC_WORD_BITS-1:0] next_frame_word;
  logic [`DPC_CNT_BITS-1:0]  next_frame_cnt;
  logic                      next_frame_seen;

  always_comb begin
    next_frame_word = frame_word;
    next_frame_cnt  = frame_cnt;
    next_frame_seen = sync_rise && spi_mode;
    if (sync_rise) begin
      next_frame_word = rx_word;
      next_frame_cnt  = edge_count;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_word <= '0;
      frame_cnt  <= '0;
      frame_seen <= 1'b0;
    end else begin
      frame_word <= next_frame_word;
      frame_cnt  <= next_frame_cnt;
      frame_seen <= next_frame_seen;
    end
  end

  // ----------------------------------------------------------------
  // Command fields
  // ----------------------------------------------------------------
  logic [3:0] cmd_field;
  logic [3:0] target_field;
  logic [7:0] payload;
  logic       frame_ok;
  logic       frame_go;

  assign cmd_field    = frame_word[`DPC_CTL_HI:`DPC_CTL_LO];
  assign target_field = frame_word[`DPC_ADR_HI:`DPC_ADR_LO];
  assign payload      = frame_word[`DPC_DAT_HI:0];
  assign frame_ok = ((frame_cnt & `DPC_UNIT_MASK) == '0) && (frame_cnt >= `DPC_MIN_EDGES);
  assign frame_go = frame_seen && frame_ok && (state == DPC_IDLE);

  // ----------------------------------------------------------------
  // Decoder, wiper and nonvolatile store
  // ----------------------------------------------------------------
  logic [TW-1:0] timer;
  logic [7:0]    pending;
  dpc_state_t    next_state;
  logic [TW-1:0] next_timer;
  logic [7:0]    next_pending;
  logic [7:0]    next_wiper;
  logic [7:0]    next_preload;
  logic [7:0]    next_nv;
  logic [7:0]    next_readback;
  logic          next_shutdown;

  always_comb begin
    next_state    = state;
    next_timer    = timer;
    next_pending  = pending;
    next_wiper    = wiper_setting_register;
    next_preload  = preload;
    next_nv       = nv_copy;
    next_readback = readback;
    next_shutdown = shutdown;
    case (state)
      DPC_BOOT: begin
        next_wiper = step_mask(nv_copy);
        next_state = DPC_IDLE;
      end
      DPC_STORE: begin
        if (timer == '0) begin
          next_nv    = pending;
          next_state = DPC_IDLE;
        end else begin
          next_timer = timer - TW'(1);
        end
      end
      default: begin
        if (frame_go) begin
          case (cmd_field)
            `DPC_CMD_WIPER: begin
              if (target_field == '0 && !protect_on) begin
                next_wiper = step_mask(payload);
              end
            end
            `DPC_CMD_PRELOAD: begin
              if (target_field == '0) begin
                next_preload = payload;
              end
            end
            `DPC_CMD_READ: begin
              if (target_field[2:0] == '0) begin
                if (payload[1:0] == `DPC_SEL_NV) begin
                  next_readback = step_mask(nv_copy);
                end else if (payload[1:0] == `DPC_SEL_WIPER) begin
                  next_readback = step_mask(wiper_setting_register);
                end else begin
                  next_readback = '0;
                end
              end
            end
            `DPC_CMD_NVCOPY: begin
              if (target_field[1:0] == '0) begin
                if (payload[0] && !protect_on) begin
                  next_pending = step_mask(wiper_setting_register);
                  next_timer   = TW'(STORE_CYCLES - 1);
                  next_state   = DPC_STORE;
                end else if (!payload[0]) begin
                  next_wiper = step_mask(nv_copy);
                end
              end
            end
            `DPC_CMD_SWRESET: begin
              next_wiper    = step_mask(nv_copy);
              next_shutdown = 1'b0;
            end
            `DPC_CMD_SHUTDOWN: begin
              if (target_field == '0) begin
                next_shutdown = payload[0];
              end
            end
            default: begin
              next_state = DPC_IDLE;
            end
          endcase
        end
      end
    endcase
    if (load_on && !protect_on && state != DPC_BOOT) begin
      next_wiper = step_mask(preload);
    end
    if (reset_on) begin
      next_wiper = step_mask(nv_copy);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state                  <= DPC_BOOT;
      timer                  <= '0;
      pending                <= '0;
      wiper_setting_register <= '0;
      preload                <= '0;
      nv_copy                <= NV_INIT;
      readback               <= '0;
      shutdown               <= 1'b0;
      busy                   <= 1'b0;
    end else begin
      state                  <= next_state;
      timer                  <= next_timer;
      pending                <= next_pending;
      wiper_setting_register <= next_wiper;
      preload                <= next_preload;
      nv_copy                <= next_nv;
      readback               <= next_readback;
      shutdown               <= next_shutdown;
      busy                   <= (next_state == DPC_STORE);
    end
  end

  // linear tap code: the wiper code drives the tap directly

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic pins_quiet;
  assign pins_quiet = !load_on && !reset_on;

  a_word_direct: assert property (
    frame_go && cmd_field == `DPC_CMD_WIPER && target_field == '0 && !protect_on && pins_quiet
    |=> wiper_setting_register == step_mask($past(frame_word[7:0])))
    else $error("wiper not written from word");

  a_preload_only: assert property (
    frame_go && cmd_field == `DPC_CMD_PRELOAD && target_field == '0 && pins_quiet
    |=> preload == $past(payload) && $stable(wiper_setting_register))
    else $error("preload write wrong");

  a_nop_quiet: assert property (
    frame_go && cmd_field == `DPC_CMD_NOP && pins_quiet
    |=> $stable(wiper_setting_register) && $stable(preload) && $stable(nv_copy) && !busy)
    else $error("nop changed state");

  a_read_select: assert property (
    frame_go && cmd_field == `DPC_CMD_READ && target_field[2:0] == '0
    && payload[1:0] == `DPC_SEL_WIPER
    |=> readback == step_mask($past(wiper_setting_register)))
    else $error("readback of wiper wrong");

  a_store_lock: assert property (
    $rose(busy) |-> busy [*8])
    else $error("store lock too short");

  a_store_commit: assert property (
    $fell(busy) |-> nv_copy == pending)
    else $error("store did not commit");

  a_protect_nv: assert property (
    protect_on && !busy |=> $stable(nv_copy))
    else $error("nv changed under protect");

  a_load_pin: assert property (
    load_on && !protect_on && !reset_on && state != DPC_BOOT
    |=> wiper_setting_register == step_mask($past(preload)))
    else $error("load pin transfer missing");

  a_reset_pin: assert property (
    reset_on |=> wiper_setting_register == step_mask($past(nv_copy)))
    else $error("reset pin refresh missing");

  a_frame_bytes: assert property (
    frame_seen && (frame_cnt[2:0] != 3'h0 || frame_cnt < `DPC_MIN_EDGES)
    && state == DPC_IDLE && pins_quiet
    |=> $stable(wiper_setting_register) && $stable(preload) && $stable(shutdown)
    && $stable(readback) && !busy)
    else $error("bad frame acted on");

  a_boot_load: assert property (
    state == DPC_BOOT && !load_on |=> wiper_setting_register == step_mask($past(nv_copy)))
    else $error("power-up restore missing");

  c_store: cover property ($rose(busy) ##1 busy [*3]);
  c_read:  cover property (frame_go && cmd_field == `DPC_CMD_READ);
  c_load:  cover property (load_on && !protect_on);
  c_drop:  cover property (frame_seen && !frame_ok);
endmodule : dpc_core

// >>> dv/dpc_host.sv
// Purpose: Host model driving the serial link of the command decoder
// Assumes: Clock idles low; 12 ns serial period; sdo arrives pulled up
// Notes:   Serial clock stands still between frames
`timescale 1ns/100ps

module dpc_host (
  // Link pins
  output logic      sclk,
  output logic      sync_n,
  output logic      sdi,
  // Pulled-up readback line
  input  wire logic sdo
);
  logic [31:0] rd_word;

  initial begin
    sclk    = 1'b0;
    sync_n  = 1'b1;
    sdi     = 1'b0;
    rd_word = 32'h0;
  end

  // --------------------------------------------------------------
  // Frame transfer
  // --------------------------------------------------------------
  // Msb first, caller picks count
  // A rising edge ahead of the first fall lets the device put out its first bit
  task automatic send(input logic [31:0] w, input int nbits);
    #1.3;
    sync_n = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      #3;
      sdi = w[i];
      #3;
      sclk = 1'b1;
      #6;
      sclk = 1'b0;
      rd_word = {rd_word[30:0], sdo};
    end
    #6;
    sync_n = 1'b1;
    // No longer held: show the inverse so no stale bit is trusted
    sdi = ~sdi;
    #40;
  endtask : send
endmodule : dpc_host

// >>> dv/tb_dpc_core.sv
// Purpose: Self-checking bench of the potentiometer command decoder
// Assumes: Short store time; second instance models the 128-step part
// Notes:   Pins change 1 ns after the rising edge of clk
`timescale 1ns/100ps
`include "dpc_params.svh"

module tb_dpc_core;
  import dpc_pkg::*;
  localparam int unsigned STORE_N = 200;
  logic       clk, rst, sclk, sync_n, sdi, sdo_o, sdo_oe_n, sdo_line;
  logic       load_wiper_n, write_protect_n, reset_n, interface_select;
  logic       shutdown, busy;
  logic [7:0] wiper, preload, nv_copy, half_wiper;
  dpc_state_t state;
  int         error_cnt;
  int         n_tests;

  // Open-drain line with pull-up
  assign sdo_line = sdo_oe_n ? 1'b1 : sdo_o;

  dpc_host u_host (.sclk(sclk), .sync_n(sync_n), .sdi(sdi), .sdo(sdo_line));

  dpc_core #(.HALF_STEPS(1'b0), .STORE_CYCLES(STORE_N)) u_dut (
    .clk(clk), .rst(rst), .sclk(sclk), .sync_n(sync_n), .sdi(sdi),
    .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .load_wiper_n(load_wiper_n),
    .write_protect_n(write_protect_n), .reset_n(reset_n),
    .interface_select(interface_select), .wiper_setting_register(wiper),
    .preload(preload), .nv_copy(nv_copy), .shutdown(shutdown), .busy(busy),
    .state(state));

  dpc_core #(.HALF_STEPS(1'b1), .STORE_CYCLES(STORE_N)) u_dut_half (
    .clk(clk), .rst(rst), .sclk(sclk), .sync_n(sync_n), .sdi(sdi),
    .sdo_o(), .sdo_oe_n(), .load_wiper_n(load_wiper_n),
    .write_protect_n(write_protect_n), .reset_n(reset_n),
    .interface_select(interface_select), .wiper_setting_register(half_wiper),
    .preload(), .nv_copy(), .shutdown(), .busy(), .state());

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  // Decode lands about 4 clk after the frame; 12 leaves margin
  task automatic frame(input logic [31:0] w, input int n);
    u_host.send(w, n);
    idle(12);
  endtask : frame

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  task automatic wait_idle;
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 400) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (busy !== 1'b0) begin
      error_cnt++;
      $display("FAIL t=%0t busy=%h exp=%h", $time, busy, 1'b0);
      close_out();
    end
  endtask : wait_idle

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset;
    chk(wiper, `DPC_NV_INIT);
    chk({preload, 7'h0, shutdown}, 16'h0);
    chk({busy, 13'h0, state}, {14'h0, DPC_IDLE});
    $display("test reset done");
  endtask : t_reset

  task automatic t_write;
    frame(32'h1040, 16);
    chk(wiper, 8'h40);
    frame(32'h10bd, 16);
    chk(wiper, 8'hbd);
    frame(32'h1155, 16);
    chk(wiper, 8'hbd);
    frame(32'h1041, 16);
    chk({wiper, half_wiper}, 16'h4140);
    $display("test write done");
  endtask : t_write

  task automatic t_preload_nop;
    frame(32'h2033, 16);
    chk({preload, wiper}, 16'h3341);
    frame(32'h0fff, 16);
    chk({preload, wiper}, 16'h3341);
    frame(32'h5077, 16);
    chk({preload, wiper}, 16'h3341);
    $display("test preload and nop done");
  endtask : t_preload_nop

  task automatic t_read;
    frame(32'h3003, 16);
    frame(32'h0000, 16);
    chk(u_host.rd_word[15:0], {8'h00, 8'h41});
    frame(32'h3001, 16);
    frame(32'h0000, 16);
    chk(u_host.rd_word[15:0], {8'h00, `DPC_NV_INIT});
    frame(32'h3002, 16);
    frame(32'h0000, 16);
    chk(u_host.rd_word[15:0], 16'h0000);
    $display("test readback done");
  endtask : t_read

  task automatic t_frames;
    frame(32'h1066, 15);
    chk(wiper, 8'h41);
    frame(32'h1066, 17);
    chk(wiper, 8'h41);
    frame(32'h1010, 16);
    frame(32'h3003, 16);
    frame(32'h0066, 8);
    chk(wiper, 8'h10);
    frame(32'h2011_1066, 32);
    chk({preload, wiper}, 16'h3366);
    interface_select = 1'b1;
    frame(32'h1077, 16);
    chk(wiper, 8'h66);
    interface_select = 1'b0;
    $display("test framing done");
  endtask : t_frames

  task automatic t_store;
    frame(32'h1022, 16);
    frame(32'h7001, 16);
    chk(busy, 1'b1);
    frame(32'h1099, 16);
    chk(wiper, 8'h22);
    wait_idle();
    chk(nv_copy, 8'h22);
    frame(32'h1055, 16);
    frame(32'h7000, 16);
    chk(wiper, 8'h22);
    $display("test store done");
  endtask : t_store

  task automatic t_pins;
    load_wiper_n = 1'b0;
    idle(6);
    load_wiper_n = 1'b1;
    idle(4);
    chk(wiper, 8'h33);
    write_protect_n = 1'b0;
    frame(32'h1011, 16);
    frame(32'h2044, 16);
    load_wiper_n = 1'b0;
    idle(6);
    load_wiper_n = 1'b1;
    idle(4);
    chk(wiper, 8'h33);
    frame(32'h7001, 16);
    chk(busy, 1'b0);
    frame(32'h7000, 16);
    chk(wiper, 8'h22);
    write_protect_n = 1'b1;
    frame(32'h1077, 16);
    reset_n = 1'b0;
    idle(6);
    reset_n = 1'b1;
    idle(4);
    chk(wiper, 8'h22);
    $display("test pins done");
  endtask : t_pins

  task automatic t_soft;
    frame(32'hc001, 16);
    chk(shutdown, 1'b1);
    frame(32'hc000, 16);
    chk(shutdown, 1'b0);
    frame(32'hc001, 16);
    frame(32'h1077, 16);
    frame(32'hb000, 16);
    chk({wiper, 7'h0, shutdown}, 16'h2200);
    $display("test soft commands done");
  endtask : t_soft

  initial begin
    error_cnt        = 0;
    n_tests          = 0;
    rst              = 1'b1;
    load_wiper_n     = 1'b1;
    write_protect_n  = 1'b1;
    reset_n          = 1'b1;
    interface_select = 1'b0;
    idle(8);
    rst = 1'b0;
    idle(4);
    t_reset();
    t_write();
    t_preload_nop();
    t_read();
    t_frames();
    t_store();
    t_pins();
    t_soft();
    close_out();
  end
endmodule : tb_dpc_core
